// file: hw/drc_regs.svh
// timing figures and derived cycle counts for the dram access controller
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

// system clock period
`define DRC_CLK_NS        20

// least time rounds up, longest time rounds down
`define DRC_CEIL_CYC(ns)  (((ns) + `DRC_CLK_NS - 1) / `DRC_CLK_NS)
`define DRC_FLOOR_CYC(ns) ((ns) / `DRC_CLK_NS)

// strobe timing in ns, slower grade figures serve both grades
`define DRC_T_RAS_NS      200
`define DRC_T_RAS_MAX_NS  75000
`define DRC_T_RC_NS       315
`define DRC_T_RP_NS       105
`define DRC_T_RAH_NS      25
`define DRC_T_RCD_NS      40
`define DRC_T_RAC_NS      200
`define DRC_T_CAC_NS      35
`define DRC_T_CAA_NS      90
`define DRC_T_POWERUP_NS  100000
`define DRC_T_REF_NS      32000000

// array shape and start-up sequence
`define DRC_ROWS          512
`define DRC_INIT_CYCLES   8
`define DRC_ADDR_W        9

// derived cycle counts
`define DRC_RAS_CYC     `DRC_CEIL_CYC(`DRC_T_RAS_NS)
`define DRC_RAS_MAX_CYC `DRC_FLOOR_CYC(`DRC_T_RAS_MAX_NS)
`define DRC_RC_CYC      `DRC_CEIL_CYC(`DRC_T_RC_NS)
`define DRC_RP_CYC      `DRC_CEIL_CYC(`DRC_T_RP_NS)
`define DRC_RAH_CYC     `DRC_CEIL_CYC(`DRC_T_RAH_NS)
`define DRC_RCD_CYC     `DRC_CEIL_CYC(`DRC_T_RCD_NS)
`define DRC_RAC_CYC     `DRC_CEIL_CYC(`DRC_T_RAC_NS)
`define DRC_CAC_CYC     `DRC_CEIL_CYC(`DRC_T_CAC_NS)
`define DRC_CAA_CYC     `DRC_CEIL_CYC(`DRC_T_CAA_NS)
`define DRC_POWERUP_CYC `DRC_CEIL_CYC(`DRC_T_POWERUP_NS)
`define DRC_REF_CYC     `DRC_FLOOR_CYC(`DRC_T_REF_NS / `DRC_ROWS)
`define DRC_REF_SLACK   64

// edge indices inside one strobe cycle, counted from the row strobe fall
`define DRC_COL_K    (`DRC_RAH_CYC - 1)
`define DRC_CAS_K    drc_pkg::drc_max(`DRC_RAH_CYC, `DRC_RCD_CYC)
`define DRC_SAMPLE_K drc_pkg::drc_max(`DRC_RAC_CYC, drc_pkg::drc_max( \
    `DRC_CAS_K + 1 + `DRC_CAC_CYC, `DRC_RAH_CYC + `DRC_CAA_CYC))
`define DRC_END_K    drc_pkg::drc_max(`DRC_RAS_CYC - 1, `DRC_SAMPLE_K)
`define DRC_REF_END_K (`DRC_RAS_CYC - 1)
`define DRC_PRE_CYC  drc_pkg::drc_max(`DRC_RP_CYC, \
    `DRC_RC_CYC - (`DRC_END_K + 1))

`endif

// file: hw/drc_pkg.sv
// types and helper arithmetic for the dram access controller
`default_nettype none

package drc_pkg;

    // controller sequencing states
    typedef enum logic [2:0] {
        st_power,
        st_idle,
        st_ras,
        st_pre
    } drc_state_type;

    // larger of two cycle counts
    function automatic int drc_max(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : drc_max

endpackage : drc_pkg

`default_nettype wire

// file: hw/drc_timer.sv
// power-up pause and per-row refresh interval timer
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"

module drc_timer #(
    parameter int unsigned POWERUP_CYC = `DRC_POWERUP_CYC,
    parameter int unsigned REF_CYC     = `DRC_REF_CYC
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    // timer results
    output var  logic o_up_done,
    output var  logic o_ref_tick
);

    logic [15:0] up_cnt_reg;
    logic [15:0] ref_cnt_reg;
    logic        up_done_reg;
    logic        tick_reg;

    wire up_last  = (up_cnt_reg == 16'(POWERUP_CYC - 1));
    wire ref_last = (ref_cnt_reg == 16'(REF_CYC - 1));

    // pause after power-up, then one refresh tick per row interval
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            up_cnt_reg  <= 16'h0000;
            ref_cnt_reg <= 16'h0000;
            up_done_reg <= 1'b0;
            tick_reg    <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (!up_done_reg) begin
                up_cnt_reg  <= up_cnt_reg + 16'h0001;
                up_done_reg <= up_last;
            end else if (ref_last) begin
                ref_cnt_reg <= 16'h0000;
                tick_reg    <= 1'b1;
            end else begin
                ref_cnt_reg <= ref_cnt_reg + 16'h0001;
            end
        end
    end

    assign o_up_done  = up_done_reg;
    assign o_ref_tick = tick_reg;

endmodule : drc_timer
`default_nettype wire

// file: hw/drc_ctrl.sv
// host-side controller for an asynchronous 256K x 1 dynamic ram
`timescale 1ns/1ps
`default_nettype none
`include "drc_regs.svh"

module drc_ctrl #(
    parameter int unsigned POWERUP_CYC = `DRC_POWERUP_CYC
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // user request
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [17:0] i_addr,
    input  wire logic        i_wdata,
    output var  logic        o_ready,
    output var  logic        o_rdata,
    output var  logic        o_rvalid,
    output var  logic        o_init_done,
    // memory pins
    output var  logic        o_ras_n,
    output var  logic        o_cas_n,
    output var  logic        o_we_n,
    output var  logic [8:0]  o_addr,
    output var  logic        o_din,
    input  wire logic        i_dout
);

    localparam logic [7:0] COL_K     = 8'(`DRC_COL_K);
    localparam logic [7:0] CAS_K     = 8'(`DRC_CAS_K);
    localparam logic [7:0] SAMPLE_K  = 8'(`DRC_SAMPLE_K);
    localparam logic [7:0] END_K     = 8'(`DRC_END_K);
    localparam logic [7:0] REF_END_K = 8'(`DRC_REF_END_K);
    localparam logic [7:0] PRE_LAST  = 8'(`DRC_PRE_CYC - 1);
    localparam logic [3:0] INIT_N    = 4'(`DRC_INIT_CYCLES);

    drc_pkg::drc_state_type state_reg, state_next;
    logic [7:0] cnt_reg,      cnt_next;
    logic [3:0] init_reg,     init_next;
    logic [8:0] ref_row_reg,  ref_row_next;
    logic [8:0] col_reg,      col_next;
    logic [8:0] addr_reg,     addr_next;
    logic       is_ref_reg,   is_ref_next;
    logic       is_wr_reg,    is_wr_next;
    logic       wbit_reg,     wbit_next;
    logic       ref_pend_reg, ref_pend_next;
    logic       ras_n_reg,    ras_n_next;
    logic       cas_n_reg,    cas_n_next;
    logic       we_n_reg,     we_n_next;
    logic       din_reg,      din_next;
    logic       rdata_reg,    rdata_next;
    logic       rvalid_reg,   rvalid_next;
    logic       ready_reg,    ready_next;
    logic       done_reg,     done_next;
    logic       up_done;
    logic       ref_tick;

    // power-up pause and refresh interval
    drc_timer #(
        .POWERUP_CYC (POWERUP_CYC),
        .REF_CYC     (`DRC_REF_CYC)
    ) u_timer (
        .i_clk_sys  (i_clk_sys),
        .i_rstn     (i_rstn),
        .o_up_done  (up_done),
        .o_ref_tick (ref_tick)
    );

    // request and refresh arbitration in idle
    wire in_idle   = (state_reg == drc_pkg::st_idle);
    wire init_busy = (init_reg != INIT_N);
    wire take_req  = in_idle && ready_reg && i_req;
    wire start_ref = in_idle && !take_req && (init_busy || ref_pend_reg);
    wire end_hit   = (cnt_reg == (is_ref_reg ? REF_END_K : END_K));
    wire is_read   = !is_ref_reg && !is_wr_reg;

    // sequencing of strobes, address and data
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        init_next     = init_reg;
        ref_row_next  = ref_row_reg;
        col_next      = col_reg;
        addr_next     = addr_reg;
        is_ref_next   = is_ref_reg;
        is_wr_next    = is_wr_reg;
        wbit_next     = wbit_reg;
        ras_n_next    = ras_n_reg;
        cas_n_next    = cas_n_reg;
        we_n_next     = we_n_reg;
        din_next      = din_reg;
        rdata_next    = rdata_reg;
        rvalid_next   = 1'b0;
        // a tick in the clearing cycle is kept
        ref_pend_next = ref_tick || (ref_pend_reg && !start_ref);
        case (state_reg)
            drc_pkg::st_power: begin
                if (up_done) begin
                    state_next = drc_pkg::st_idle;
                end
            end
            drc_pkg::st_idle: begin
                if (take_req) begin
                    state_next = drc_pkg::st_ras;
                    cnt_next   = 8'h00;
                    is_ref_next = 1'b0;
                    is_wr_next = i_we;
                    wbit_next  = i_wdata;
                    col_next   = i_addr[8:0];
                    addr_next  = i_addr[17:9];
                    ras_n_next = 1'b0;
                end else if (start_ref) begin
                    // row-only cycle, also used for start-up
                    state_next  = drc_pkg::st_ras;
                    cnt_next    = 8'h00;
                    is_ref_next = 1'b1;
                    addr_next   = ref_row_reg;
                    ras_n_next  = 1'b0;
                end
            end
            drc_pkg::st_ras: begin
                cnt_next = cnt_reg + 8'h01;
                if (!is_ref_reg && cnt_reg == COL_K) begin
                    // row held two cycles before column swap
                    addr_next = col_reg;
                    // write strobe ahead of column strobe
                    we_n_next = !is_wr_reg;
                    din_next  = wbit_reg;
                end
                if (!is_ref_reg && cnt_reg == CAS_K) begin
                    cas_n_next = 1'b0;
                end
                if (is_read && cnt_reg == SAMPLE_K) begin
                    // sample only on reads, at the latest access limit
                    rdata_next  = i_dout;
                    rvalid_next = 1'b1;
                end
                if (end_hit) begin
                    // all strobes rise together; write strobe never early
                    ras_n_next = 1'b1;
                    cas_n_next = 1'b1;
                    we_n_next  = 1'b1;
                    state_next = drc_pkg::st_pre;
                    cnt_next   = 8'h00;
                    if (is_ref_reg) begin
                        ref_row_next = ref_row_reg + 9'h001;
                        if (init_busy) begin
                            init_next = init_reg + 4'h1;
                        end
                    end
                end
            end
            drc_pkg::st_pre: begin
                // precharge; data out floats well inside this
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == PRE_LAST) begin
                    state_next = drc_pkg::st_idle;
                end
            end
            default: begin
                state_next = drc_pkg::st_power;
            end
        endcase
        done_next  = (init_next == INIT_N);
        ready_next = (state_next == drc_pkg::st_idle) && done_next
            && !ref_pend_next;
    end

    // state and output flip-flops
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_reg <= drc_pkg::st_power;
            cnt_reg <= 8'h00;
            init_reg <= 4'h0;
            ref_row_reg <= 9'h000;
            col_reg <= 9'h000;
            addr_reg <= 9'h000;
            {is_ref_reg, is_wr_reg, wbit_reg, ref_pend_reg} <= 4'h0;
            {ras_n_reg, cas_n_reg, we_n_reg} <= 3'h7;
            {din_reg, rdata_reg, rvalid_reg} <= 3'h0;
            {ready_reg, done_reg} <= 2'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            init_reg <= init_next;
            ref_row_reg <= ref_row_next;
            col_reg <= col_next;
            addr_reg <= addr_next;
            {is_ref_reg, is_wr_reg} <= {is_ref_next, is_wr_next};
            {wbit_reg, ref_pend_reg} <= {wbit_next, ref_pend_next};
            {ras_n_reg, cas_n_reg, we_n_reg} <=
                {ras_n_next, cas_n_next, we_n_next};
            {din_reg, rdata_reg, rvalid_reg} <=
                {din_next, rdata_next, rvalid_next};
            {ready_reg, done_reg} <= {ready_next, done_next};
        end
    end

    assign o_ras_n     = ras_n_reg;
    assign o_cas_n     = cas_n_reg;
    assign o_we_n      = we_n_reg;
    assign o_addr      = addr_reg;
    assign o_din       = din_reg;
    assign o_rdata     = rdata_reg;
    assign o_rvalid    = rvalid_reg;
    assign o_ready     = ready_reg;
    assign o_init_done = done_reg;

    // helper counters watched by the checks
    logic        ras_q_reg;
    logic [15:0] since_reg;
    logic [15:0] ref_age_reg;
    logic [15:0] low_reg;
    logic [3:0]  falls_reg;
    wire         ras_fell = ras_q_reg && !ras_n_reg;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ras_q_reg <= 1'b1;
            since_reg <= 16'hFFFF;
            ref_age_reg <= 16'h0000;
            low_reg <= 16'h0000;
            falls_reg <= 4'h0;
        end else begin
            ras_q_reg <= ras_n_reg;
            since_reg <= ras_fell ? 16'h0001
                : (since_reg == 16'hFFFF ? since_reg : since_reg + 16'h0001);
            ref_age_reg <= (start_ref || !done_reg) ? 16'h0000
                : ref_age_reg + 16'h0001;
            low_reg <= ras_n_reg ? 16'h0000 : low_reg + 16'h0001;
            falls_reg <= (ras_fell && falls_reg != 4'hF)
                ? falls_reg + 4'h1 : falls_reg;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    chk_powerup_pause: assert property (
        $fell(o_ras_n) |-> up_done) else $error("strobe before pause");
    chk_init_cycles: assert property (
        $rose(o_init_done) |-> falls_reg >= 4'(`DRC_INIT_CYCLES))
        else $error("init done before eight row cycles");
    chk_strobe_activity: assert property (
        o_init_done |-> since_reg < 16'(`DRC_REF_CYC + `DRC_REF_SLACK))
        else $error("strobes idle too long");
    chk_refresh_gap: assert property (
        ref_age_reg < 16'(`DRC_REF_CYC + `DRC_REF_SLACK))
        else $error("row refresh interval exceeded");
    chk_cycle_time: assert property (
        ras_fell |-> since_reg >= 16'(`DRC_RC_CYC))
        else $error("row cycle too short");
    chk_row_hold: assert property (
        $fell(o_ras_n) |=> $stable(o_addr)) else $error("row addr moved");
    chk_ras_to_cas: assert property (
        $fell(o_cas_n) |-> !o_ras_n && $past(!o_ras_n, 2))
        else $error("column strobe too soon");
    chk_read_we_high: assert property (
        $rose(o_ras_n) && is_read |-> o_we_n ##1 o_we_n)
        else $error("write strobe low at read end");
    chk_early_write: assert property (
        $fell(o_cas_n) && is_wr_reg |-> !o_we_n && $past(!o_we_n))
        else $error("write strobe not early");
    chk_write_hold: assert property (
        $fell(o_cas_n) && !o_we_n |-> !o_we_n [*2])
        else $error("write strobe hold short");
    chk_we_lead: assert property (
        $rose(o_ras_n) && $past(!o_we_n) |-> $past(!o_we_n, 2))
        else $error("write strobe lead short");
    chk_col_setup: assert property (
        $rose(o_ras_n) && !is_ref_reg |-> $past(o_addr, 5) == $past(o_addr))
        else $error("column address too late");
    chk_we_precharge: assert property (
        $fell(o_ras_n) |-> $past(o_we_n)) else $error("write strobe low");
    chk_ras_width: assert property (
        low_reg < 16'(`DRC_RAS_MAX_CYC)) else $error("row strobe too long");

    cov_read: cover property (o_rvalid);
    cov_write: cover property ($fell(o_cas_n) && !o_we_n);
    cov_refresh: cover property (start_ref && done_reg);
    cov_init: cover property ($rose(o_init_done));

endmodule : drc_ctrl
`default_nettype wire

// file: sim/drc_dram_model.sv
// behavioural 256K x 1 dynamic ram that checks the controller's timing
`timescale 1ns/1ps
`default_nettype none

module drc_dram_model #(
    parameter real T_PAUSE_NS = 400.0,
    parameter real T_ACC_NS   = 200.0
) (
    // memory pins
    input  wire logic       i_ras_n,
    input  wire logic       i_cas_n,
    input  wire logic       i_we_n,
    input  wire logic [8:0] i_addr,
    input  wire logic       i_din,
    output var  logic       o_dout,
    // count of timing faults seen
    output var  int         o_viol
);
    logic       cells [0:262143];
    realtime    last_ref [0:511];
    realtime    t_rf, t_cf, t_wf, t_wr, t_ad, t_ad_old, t_ok;
    logic [8:0] row;
    logic [8:0] col;
    logic       used_cas;
    logic       wr_cyc;
    int         n_init;

    task automatic viol(input string what, input real lim, input real seen);
        o_viol++;
        $display("Error: %s expected %0.1f seen %0.1f", what, lim, seen);
    endtask : viol

    // power-up state
    initial begin
        o_dout = 1'b0;
        o_viol = 0;
        n_init = 0;
        used_cas = 1'b0;
        wr_cyc = 1'b0;
        t_rf = -1.0e6;
        t_wr = -1.0e6;
        foreach (last_ref[i]) last_ref[i] = 0.0;
    end

    // row address hold and column address timestamps
    always @(i_addr) begin
        if (!i_ras_n && i_cas_n && $realtime > t_rf
                && $realtime - t_rf < 25.0)
            viol("row address hold", 25.0, $realtime - t_rf);
        t_ad_old = t_ad;
        t_ad = $realtime;
    end

    // row strobe fall: cycle spacing, start-up, refresh interval
    always @(negedge i_ras_n) begin
        if ($realtime < T_PAUSE_NS)
            viol("start-up pause", T_PAUSE_NS, $realtime);
        if ($realtime - t_rf < 315.0)
            viol("row cycle", 315.0, $realtime - t_rf);
        if (!i_we_n || $realtime - t_wr < 10.0)
            viol("write to row", 10.0, $realtime - t_wr);
        t_rf = $realtime;
        used_cas = 1'b0;
        wr_cyc = 1'b0;
        n_init++;
        #1;
        row = i_addr;
        if (t_rf - last_ref[row] > 32.0e6)
            viol("row refresh", 32.0e6, t_rf - last_ref[row]);
        last_ref[row] = t_rf;
    end

    // column strobe fall: early write or read with access delays
    always @(negedge i_cas_n) begin
        t_cf = $realtime;
        if (t_cf - t_rf < 35.0)
            viol("row to column delay", 35.0, t_cf - t_rf);
        if (n_init < 8) viol("start-up cycles", 8.0, n_init);
        #1;
        col = i_addr;
        used_cas = 1'b1;
        if (!i_we_n) begin
            wr_cyc = 1'b1;
            cells[{row, col}] = i_din;
        end else begin
            o_dout = ~cells[{row, col}];
            t_ok = t_rf + T_ACC_NS;
            if (t_cf + 35.0 > t_ok) t_ok = t_cf + 35.0;
            if (t_ad + 90.0 > t_ok) t_ok = t_ad + 90.0;
            fork
                #(t_ok - $realtime) if (!i_cas_n) o_dout = cells[{row, col}];
            join_none
        end
    end

    // late write strobe gives read-modify-write or undefined output
    always @(negedge i_we_n) begin
        t_wf = $realtime;
        if (!i_cas_n && !wr_cyc) begin
            wr_cyc = 1'b1;
            if (t_wf - t_cf < 35.0 || t_wf - t_ad < 90.0)
                o_dout = ~o_dout;
            cells[{row, col}] = i_din;
        end
    end

    // write strobe rise: hold after column strobe
    always @(posedge i_we_n) begin
        t_wr = $realtime;
        if (wr_cyc && t_wr - t_cf < 35.0)
            viol("write hold", 35.0, t_wr - t_cf);
    end

    // column strobe rise: read command hold, output release
    always @(posedge i_cas_n) begin
        if (used_cas && !wr_cyc && !i_we_n) viol("read hold", 0.0, 1.0);
        fork
            #30 o_dout = ~o_dout;
        join_none
    end

    // row strobe rise: address lead, write lead, pulse width
    always @(posedge i_ras_n) begin
        t_ok = (t_ad == $realtime) ? t_ad_old : t_ad;
        if (used_cas && $realtime - t_ok < 90.0)
            viol("column lead", 90.0, $realtime - t_ok);
        if (wr_cyc && $realtime - t_wf < 35.0)
            viol("write lead", 35.0, $realtime - t_wf);
        // the first rise out of reset has no fall before it
        if (t_rf >= 0.0 && $realtime - t_rf > 75000.0)
            viol("row pulse", 75000.0, $realtime - t_rf);
    end

endmodule : drc_dram_model

`default_nettype wire

// file: sim/drc_ctrl_tb.sv
// self-checking bench for the dram access controller
`timescale 1ns/1ps
`default_nettype none

module drc_ctrl_tb;
    localparam int unsigned PU_CYC = 20;
    localparam int          LIM    = 4000;

    logic        i_clk_sys, i_rstn, i_req, i_we, i_wdata, i_dout;
    logic [17:0] i_addr;
    logic        o_ready, o_rdata, o_rvalid, o_init_done;
    logic        o_ras_n, o_cas_n, o_we_n, o_din;
    logic [8:0]  o_addr;
    int          viol, n_mismatch, checked, n_ras, n_cas, i, dn;
    realtime     t_rel, t_first;
    logic        shadow [logic [17:0]];
    logic [17:0] pool [0:15];

    drc_ctrl #(.POWERUP_CYC(PU_CYC)) dut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(i_req), .i_we(i_we),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_init_done(o_init_done),
        .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
        .o_addr(o_addr), .o_din(o_din), .i_dout(i_dout));

    drc_dram_model #(.T_PAUSE_NS(real'(PU_CYC) * 20.0)) mem (
        .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n),
        .i_addr(o_addr), .i_din(o_din), .o_dout(i_dout), .o_viol(viol));

    // 50 MHz clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // strobe edge counters
    always @(negedge o_ras_n) begin
        if (n_ras == 0) t_first = $realtime;
        n_ras++;
    end
    always @(negedge o_cas_n) n_cas++;

    // expected strobes, cycle k after the taking edge
    function automatic logic [2:0] exp_strobes(input int k, input logic we);
        return {k > 10, !(k >= 3 && k <= 10), !(we && k >= 2 && k <= 10)};
    endfunction : exp_strobes

    task automatic test_done();
        n_mismatch += viol;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [17:0] e,
                       input logic [17:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error: %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk

    task automatic tick();
        @(posedge i_clk_sys);
        #1;
    endtask : tick

    // bounded wait for the ready level
    task automatic wait_ready();
        int n;
        n = 0;
        while (o_ready !== 1'b1) begin
            tick();
            n++;
            if (n > LIM) begin
                chk("ready wait", 18'h1, 18'h0);
                test_done();
            end
        end
    endtask : wait_ready

    task automatic do_reset();
        i_rstn = 1'b0;
        repeat (3) tick();
        chk("strobes in reset", 18'h7, 18'({o_ras_n, o_cas_n, o_we_n}));
        chk("status in reset", 18'h0, 18'({o_ready, o_init_done, o_rvalid}));
        i_rstn = 1'b1;
        t_rel = $realtime;
        n_ras = 0;
        n_cas = 0;
        wait_ready();
        chk("start-up row cycles", 18'h8, 18'(n_ras));
        chk("start-up column strobes", 18'h0, 18'(n_cas));
        chk("start-up pause", 18'h1,
            18'(t_first - t_rel >= PU_CYC * 20.0));
        chk("init done", 18'h1, 18'(o_init_done));
    endtask : do_reset

    task automatic access(input logic we, input logic [17:0] a,
                          input logic wd);
        i_req = 1'b1;
        i_we = we;
        i_addr = a;
        i_wdata = wd;
        wait_ready();
        tick();
        i_req = 1'b0;
        i_addr = 18'($urandom);
        for (int k = 0; k <= 11; k++) begin
            chk("strobes", 18'(exp_strobes(k, we)),
                18'({o_ras_n, o_cas_n, o_we_n}));
            // no new request is taken while a strobe cycle runs
            chk("ready low", 18'h0, 18'(o_ready));
            if (k == 0) chk("row address", 18'(a[17:9]), 18'(o_addr));
            if (k == 3) chk("column address", 18'(a[8:0]),
                18'(o_addr));
            if (k == 3 && we) chk("data in", 18'(wd), 18'(o_din));
            chk("read valid", 18'(k == 11 && !we), 18'(o_rvalid));
            if (k == 11 && !we) chk("read data", 18'(shadow[a]),
                18'(o_rdata));
            if (k < 11) tick();
        end
        if (we) shadow[a] = wd;
    endtask : access

    // main sequence
    initial begin
        i_rstn = 1'b0;
        i_req = 1'b0;
        i_we = 1'b0;
        i_addr = 18'h00000;
        i_wdata = 1'b0;
        n_mismatch = 0;
        checked = 0;
        n_ras = 0;
        n_cas = 0;
        void'($urandom(32'h4ec26edb));
        tick();
        do_reset();
        $display("test start-up done");
        // corner addresses, both data values, back to back
        access(1'b1, 18'h00000, 1'b1);
        access(1'b1, 18'h3FFFF, 1'b0);
        access(1'b0, 18'h00000, 1'b0);
        access(1'b0, 18'h3FFFF, 1'b0);
        access(1'b1, 18'h3FFFF, 1'b1);
        access(1'b0, 18'h3FFFF, 1'b0);
        $display("test corners done");
        // random writes then mixed traffic over a pool
        for (i = 0; i < 16; i++) begin
            pool[i] = 18'($urandom);
            access(1'b1, pool[i], 1'($urandom));
        end
        for (i = 0; i < 100; i++) begin
            access(1'($urandom), pool[$urandom % 16], 1'($urandom));
        end
        $display("test random traffic done");
        // idle: only row-only refresh cycles
        n_ras = 1;
        n_cas = 0;
        repeat (7000) tick();
        dn = n_ras - 1;
        chk("refresh count", 18'h1, 18'(dn >= 2 && dn <= 3));
        chk("refresh column strobes", 18'h0, 18'(n_cas));
        $display("test refresh done");
        // reset in mid-read, then data still readable
        i_req = 1'b1;
        i_we = 1'b0;
        i_addr = pool[0];
        wait_ready();
        tick();
        i_req = 1'b0;
        repeat (8) tick();
        do_reset();
        access(1'b0, pool[0], 1'b0);
        access(1'b0, pool[15], 1'b0);
        $display("test reset in mid-run done");
        test_done();
    end

endmodule : drc_ctrl_tb

`default_nettype wire
